//--- qrs_regs.svh
// Timing constants for the quasi-resonant switch timing block.
// Assumes a 125 MHz reference clock (8 ns period).
`ifndef QRS_REGS_SVH
`define QRS_REGS_SVH
`define QRS_CLK_PERIOD_NS   8
`define QRS_EVAL_PERIOD_MS  48
`define QRS_EVAL_CYCLES     ((`QRS_EVAL_PERIOD_MS * 1000000) / `QRS_CLK_PERIOD_NS)
`define QRS_OVP_BLANK_US    100
`define QRS_OVP_CYCLES      ((`QRS_OVP_BLANK_US * 1000) / `QRS_CLK_PERIOD_NS)
`define QRS_SW_BLANK_NS     190
`define QRS_SW_CYCLES       ((`QRS_SW_BLANK_NS + `QRS_CLK_PERIOD_NS - 1) / `QRS_CLK_PERIOD_NS)
`define QRS_LEB_CYCLES      28
`define QRS_MAX_ON_CYCLES   4000
`define QRS_MAX_OFF_CYCLES  6250
`define QRS_RING_SHORT_CYC  313
`define QRS_RING_LONG_CYC   3125
`define QRS_VALLEY_MIN      3'h1
`define QRS_VALLEY_MAX      3'h7
`define QRS_ZC_MAX          3'h7
`endif

//--- qrs_pkg.sv
// Types shared by the quasi-resonant switch timing block.
// No assumptions beyond a SystemVerilog compiler.
package qrs_pkg;
  // Comparator levels, raw or synchronised
  typedef struct packed {
    logic fb_above_up;     // Feedback above count_up_threshold
    logic fb_above_down;   // Feedback above count_down_threshold
    logic fb_above_reset;  // Feedback above counter_reset_threshold
    logic zc_below_detect; // Zero-crossing input below crossing_detect_level
    logic zc_above_ovp;    // Above output_overvoltage_level
    logic zc_below_ring;   // Below ringing_select_level
    logic sense_above_fb;  // Scaled_sense_voltage above feedback_voltage
    logic current_limit;   // Cycle-by-cycle limit
    logic short_winding;   // Above short_winding_level
  } qrs_cmp_s;

  typedef enum logic [1:0] {
    QRS_OFF_RING,
    QRS_OFF_WAIT,
    QRS_ON,
    QRS_LATCHED
  } qrs_state_e;
endpackage

//--- qrs_blank_timer.sv
// Continuous-assertion blanking timer: fires after the input stays high.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`default_nettype none
module qrs_blank_timer #(
  parameter int CYCLES = 16,
  parameter int WIDTH  = 16
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // Level in, qualified level out
  input  wire logic i_level,
  output logic      o_expired
);
  logic [WIDTH-1:0] count_r;

  // Count while asserted, restart on any drop
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || !i_level) begin
      count_r <= '0;
    end else if (count_r != WIDTH'(CYCLES)) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign o_expired = i_level && (count_r == WIDTH'(CYCLES));
endmodule
`default_nettype wire

//--- qrs_switch_timing.sv
// Switching-timing logic of a quasi-resonant flyback controller.
// Assumes asynchronous analog comparator outputs and one 125 MHz clock.
// Notes on behaviour
// R1: Evaluate feedback every 48 ms period.
// R2: Always below up threshold: increment, max 7.
// R3: Above up, never above down: hold.
// R4: Above down, never reset threshold: decrement.
// R5: Above reset threshold forces counter to 1.
// R6: Valley count stays within 1 to 7.
// R7: Valley count starts at 1.
// R8: Count falling crossings after turn-off, 0-7.
// R9: Clear crossing count at each turn-on.
// R10: Off-time overvoltage held blanking time latches off.
// R11: Ringing comparator picks long or short time.
// R12: No turn-on during ringing suppression.
// R13: Turn on when crossings reach valley count.
// R14: Maximum off-time forces turn-on.
// R15: Sense above feedback turns switch off.
// R16: Leading-edge blanking masks sense comparators.
// R17: Maximum on-time forces turn-off.
// R18: Current limit turns off after blanking.
// R19: Short winding needs spike blanking time.
// R20: Overvoltage blanking is 100 us.
// R21: Short winding only on-time; power-down clears.
// R22: Synchronise inputs; sticky flags per period.
// R23: Durations are parameterised cycle counters.
`timescale 1ns/1ps
`default_nettype none
`include "qrs_regs.svh"
module qrs_switch_timing
  import qrs_pkg::*;
#(
  parameter int EVAL_CYCLES     = `QRS_EVAL_CYCLES,
  parameter int OVP_CYCLES      = `QRS_OVP_CYCLES,
  parameter int SW_CYCLES       = `QRS_SW_CYCLES,
  parameter int LEB_CYCLES      = `QRS_LEB_CYCLES,
  parameter int MAX_ON_CYCLES   = `QRS_MAX_ON_CYCLES,
  parameter int MAX_OFF_CYCLES  = `QRS_MAX_OFF_CYCLES,
  parameter int RING_SHORT_CYC  = `QRS_RING_SHORT_CYC,
  parameter int RING_LONG_CYC   = `QRS_RING_LONG_CYC
) (
  // Clock and synchronous reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // Power-down indication clears latch-off
  input  wire logic i_power_down,
  // Asynchronous comparator outputs
  input  wire qrs_cmp_s i_cmp,
  // Gate drive and status
  output logic       o_gate_drive_output,
  output logic       o_latched_off,
  output logic [2:0] o_valley_count,
  output logic [2:0] o_zc_count
);
  localparam int TW = 24;
  localparam int EW = 23;

  qrs_cmp_s   sync1_r;
  qrs_cmp_s   sync2_r;
  logic       pd_sync1_r;
  logic       pd_sync2_r;
  logic       zc_prev_r;
  qrs_state_e state_r;
  logic [TW-1:0] phase_cnt_r;
  logic [TW-1:0] ring_len_r;
  logic [EW-1:0] eval_cnt_r;
  logic       seen_up_r;
  logic       seen_down_r;
  logic       seen_reset_r;
  logic [2:0] valley_r;
  logic [2:0] zc_cnt_r;
  logic       ovp_expired;
  logic       sw_expired;
  logic       eval_end;
  logic       zc_fall;
  logic       turn_on;
  logic       turn_off;
  logic       leb_done;

  // Two-stage synchronisers for all comparators [R22]
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      pd_sync1_r <= 1'b0;
      pd_sync2_r <= 1'b0;
    end else begin
      sync1_r    <= i_cmp;
      sync2_r    <= sync1_r;
      pd_sync1_r <= i_power_down;
      pd_sync2_r <= pd_sync1_r;
    end
  end

  // Falling crossing edge detect, on synchronised level
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      zc_prev_r <= 1'b1;
    end else begin
      zc_prev_r <= sync2_r.zc_below_detect;
    end
  end
  assign zc_fall = sync2_r.zc_below_detect && !zc_prev_r;

  // Evaluation period counter [R1]
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || eval_end) begin
      eval_cnt_r <= '0;
    end else begin
      eval_cnt_r <= eval_cnt_r + 1'b1;
    end
  end
  assign eval_end = (eval_cnt_r == EW'(EVAL_CYCLES - 1));

  // Sticky "once higher" flags, cleared at each evaluation [R22]
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || eval_end) begin
      seen_up_r    <= 1'b0;
      seen_down_r  <= 1'b0;
      seen_reset_r <= 1'b0;
    end else begin
      seen_up_r    <= seen_up_r | sync2_r.fb_above_up;
      seen_down_r  <= seen_down_r | sync2_r.fb_above_down;
      seen_reset_r <= seen_reset_r | sync2_r.fb_above_reset;
    end
  end

  // Valley-selection up/down counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      valley_r <= `QRS_VALLEY_MIN;                       // [R7]
    end else if (sync2_r.fb_above_reset) begin
      valley_r <= `QRS_VALLEY_MIN;                       // [R5]
    end else if (eval_end) begin                         // [R1]
      if (seen_reset_r) begin
        valley_r <= `QRS_VALLEY_MIN;                     // [R5]
      end else if (seen_down_r || sync2_r.fb_above_down) begin // Last cycle counts too
        if (valley_r != `QRS_VALLEY_MIN) begin           // [R6]
          valley_r <= valley_r - 3'h1;                   // [R4]
        end
      end else if (!seen_up_r && !sync2_r.fb_above_up) begin
        if (valley_r != `QRS_VALLEY_MAX) begin           // [R6]
          valley_r <= valley_r + 3'h1;                   // [R2]
        end
      end                                                // Hold [R3]
    end
  end

  // Zero-crossing counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || turn_on) begin
      zc_cnt_r <= '0;                                    // [R9]
    end else if (state_r != QRS_ON && zc_fall && zc_cnt_r != `QRS_ZC_MAX) begin
      zc_cnt_r <= zc_cnt_r + 3'h1;                       // [R8]
    end
  end

  // Overvoltage blanking, only during off-time [R10] [R20]
  qrs_blank_timer #(
    .CYCLES (OVP_CYCLES),
    .WIDTH  (16)
  ) u_ovp_blank (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_level   (sync2_r.zc_above_ovp && (state_r == QRS_OFF_RING || state_r == QRS_OFF_WAIT)),
    .o_expired (ovp_expired)
  );

  // Short-winding spike blanking, only during on-time [R19] [R21]
  qrs_blank_timer #(
    .CYCLES (SW_CYCLES),
    .WIDTH  (8)
  ) u_sw_blank (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_level   (sync2_r.short_winding && (state_r == QRS_ON)),
    .o_expired (sw_expired)
  );

  // Phase timer and turn decisions [R23]
  assign leb_done = (phase_cnt_r >= TW'(LEB_CYCLES));   // [R16]
  assign turn_off = (state_r == QRS_ON) &&
                    ((leb_done && (sync2_r.sense_above_fb ||    // [R15]
                                   sync2_r.current_limit)) ||   // [R18]
                     (phase_cnt_r >= TW'(MAX_ON_CYCLES)));      // [R17]
  assign turn_on  = (state_r == QRS_OFF_WAIT) &&
                    ((zc_cnt_r >= valley_r) ||                  // [R13]
                     (phase_cnt_r >= TW'(MAX_OFF_CYCLES)));     // [R14]

  // Main switch state machine
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_r     <= QRS_OFF_RING;
      phase_cnt_r <= '0;
      ring_len_r  <= TW'(RING_LONG_CYC);
    end else if (state_r == QRS_LATCHED) begin
      if (pd_sync2_r) begin                              // [R21]
        state_r     <= QRS_OFF_RING;
        phase_cnt_r <= '0;
      end
    end else if (ovp_expired || sw_expired) begin        // [R10] [R19]
      state_r     <= QRS_LATCHED;
      phase_cnt_r <= '0;
    end else begin
      case (state_r)
        QRS_ON: begin
          if (turn_off) begin
            state_r     <= QRS_OFF_RING;
            phase_cnt_r <= '0;
            ring_len_r  <= sync2_r.zc_below_ring ? TW'(RING_LONG_CYC)
                                                 : TW'(RING_SHORT_CYC); // [R11]
          end else begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
          end
        end
        QRS_OFF_RING: begin
          phase_cnt_r <= phase_cnt_r + 1'b1;             // Off-time keeps counting
          if (phase_cnt_r + 1'b1 >= ring_len_r) begin    // [R12]
            state_r <= QRS_OFF_WAIT;
          end
        end
        QRS_OFF_WAIT: begin
          if (turn_on) begin
            state_r     <= QRS_ON;
            phase_cnt_r <= '0;
          end else begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= QRS_OFF_RING;
        end
      endcase
    end
  end

  // Outputs
  assign o_gate_drive_output = (state_r == QRS_ON);
  assign o_latched_off       = (state_r == QRS_LATCHED);
  assign o_valley_count      = valley_r;
  assign o_zc_count          = zc_cnt_r;
endmodule
`default_nettype wire

//--- qrs_switch_checker.sv
// Port assertions for the switch timing block.
// Assumes bind from the block, which hands on its timing parameters.
`timescale 1ns/1ps
`default_nettype none
module qrs_switch_checker #(
  parameter int LEB_CYCLES     = 28,
  parameter int MAX_ON_CYCLES  = 4000,
  parameter int MAX_OFF_CYCLES = 6250,
  parameter int RING_SHORT_CYC = 313
) (
  // Watched ports
  input wire logic       i_ref_clk,
  input wire logic       i_reset_n,
  input wire logic       i_power_down,
  input wire logic       o_gate_drive_output,
  input wire logic       o_latched_off,
  input wire logic [2:0] o_valley_count,
  input wire logic [2:0] o_zc_count
);
  wire        g = o_gate_drive_output;
  wire  [2:0] v = o_valley_count;
  wire  [2:0] z = o_zc_count;
  logic [15:0] on_r;
  logic [15:0] off_r;
  // Cycles spent at the present gate level
  always_ff @(posedge i_ref_clk) begin
    on_r  <= (i_reset_n && g) ? on_r + 16'h0001 : 16'h0000;
    off_r <= (i_reset_n && !g) ? off_r + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_on; $rose(g); endsequence
  sequence s_off; $fell(g) && !o_latched_off; endsequence
  on_min_a: assert property (s_off |-> on_r >= LEB_CYCLES) else $error("on below blanking");
  on_max_a: assert property (g |-> on_r <= MAX_ON_CYCLES + 2) else $error("on too long");
  ring_wait_a: assert property (s_on |-> off_r >= RING_SHORT_CYC) else $error("on in ringing");
  turn_on_a: assert property (s_on |-> $past(z) >= $past(v) || off_r >= MAX_OFF_CYCLES - 1)
    else $error("early turn-on");
  zc_clear_a: assert property (g |-> z == 3'h0) else $error("crossings while on");
  zc_step_a: assert property (!g && $changed(z) |-> z == $past(z) + 3'h1) else $error("crossing step");
  valley_range_a: assert property (v != 3'h0) else $error("valley zero");
  valley_step_a: assert property ($changed(v) |-> v == $past(v) + 3'h1 || v == $past(v) - 3'h1 || v == 3'h1)
    else $error("valley step");
  latch_hold_a: assert property ($fell(o_latched_off) |-> $past(i_power_down, 2)) else $error("latch lost");
endmodule
bind qrs_switch_timing qrs_switch_checker #(.LEB_CYCLES(LEB_CYCLES), .MAX_ON_CYCLES(MAX_ON_CYCLES),
  .MAX_OFF_CYCLES(MAX_OFF_CYCLES), .RING_SHORT_CYC(RING_SHORT_CYC)) u_qrs_switch_checker (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_power_down(i_power_down), .o_gate_drive_output(o_gate_drive_output),
  .o_latched_off(o_latched_off), .o_valley_count(o_valley_count), .o_zc_count(o_zc_count));
`default_nettype wire

//--- qrs_analog_model.sv
// Comparator model on the far side of the switch timing block.
// Assumes the gate drive in and bench knobs; changes on falling edges.
`timescale 1ns/1ps
`default_nettype none
module qrs_analog_model
  import qrs_pkg::*;
(
  // Clock, gate and bench knobs
  input  wire logic       i_ref_clk,
  input  wire logic       i_gate,
  input  wire logic [2:0] i_fb,
  input  wire logic [3:0] i_n_ring,
  input  wire logic [7:0] i_on_len,
  input  wire logic [3:0] i_fault,
  // Comparator levels
  output var qrs_cmp_s    o_cmp
);
  logic        g_r = 1'b0;
  logic [15:0] t_r = 16'h0000;
  wire         zcb = g_r || (t_r >= {8'h00, i_n_ring, 4'h0}) || t_r[3];
  // Ringing gives n falling crossings, then the winding rests low
  initial o_cmp = '0;
  always @(negedge i_ref_clk) begin
    g_r   <= i_gate;
    t_r   <= (i_gate != g_r) ? 16'h0000 : t_r + 16'h0001;
    o_cmp <= {i_fb[0], i_fb[1], i_fb[2], zcb, i_fault[2] & ~g_r, i_fault[3],
              g_r && i_on_len != 8'h00 && t_r >= {8'h00, i_on_len}, i_fault[1] & g_r, i_fault[0] & g_r};
  end
endmodule
`default_nettype wire

//--- test_qrs_switch_timing.sv
// Self-checking bench for the switch timing block.
// Assumes the comparator model and shortened timing parameters.
`timescale 1ns/1ps
`default_nettype none
module test_qrs_switch_timing;
  import qrs_pkg::*;
  localparam int LEB = 28;
  localparam int MON = 100;
  localparam int MOFF = 400;
  localparam int RS = 20;
  localparam int RL = 60;
  logic       i_ref_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       i_power_down = 1'b0;
  logic [2:0] fb = 3'h7;
  logic [3:0] nring = 4'h1;
  logic [3:0] flt = 4'h0;
  logic [7:0] onl = 8'h28;
  qrs_cmp_s   cmp;
  logic       gate;
  logic       latched;
  logic [2:0] valley;
  logic [2:0] zc;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         hi;
  int         lo;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: mismatch", $time); end end
  // Clock, 8 ns period
  always #4 i_ref_clk = ~i_ref_clk;
  qrs_switch_timing #(.EVAL_CYCLES(200), .OVP_CYCLES(20), .LEB_CYCLES(LEB), .MAX_ON_CYCLES(MON),
    .MAX_OFF_CYCLES(MOFF), .RING_SHORT_CYC(RS), .RING_LONG_CYC(RL)) u_qrs_switch_timing (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_power_down(i_power_down), .i_cmp(cmp),
    .o_gate_drive_output(gate), .o_latched_off(latched), .o_valley_count(valley), .o_zc_count(zc));
  qrs_analog_model u_qrs_analog_model (.i_ref_clk(i_ref_clk), .i_gate(gate), .i_fb(fb), .i_n_ring(nring),
    .i_on_len(onl), .i_fault(flt), .o_cmp(cmp));
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // Length of the present gate level, bounded
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (gate === lvl && n < 999) begin
      wait_n(1);
      n++;
    end
  endtask
  // Set plant knobs, then time the second whole on/off cycle
  task automatic cfg(input logic [7:0] o, input logic [3:0] n, input logic [3:0] f);
    onl = o;
    nring = n;
    flt = f;
    repeat (2) begin
      span(1'b0, lo);
      span(1'b1, hi);
      span(1'b0, lo);
    end
  endtask
  // Main sequence
  initial begin
    wait_n(20);
    i_reset_n = 1'b1;
    wait_n(2);
    `CHK({gate, latched, valley, zc}, 8'h08)
    cfg(8'h28, 4'h1, 4'h0);
    `CHK(hi inside {[40:48]}, 1'b1)
    `CHK(lo inside {[RS:RS+4]}, 1'b1)
    cfg(8'h28, 4'h1, 4'h8);
    `CHK(lo inside {[RL:RL+4]}, 1'b1)
    cfg(8'h05, 4'h1, 4'h0);
    `CHK(hi inside {[LEB:LEB+4]}, 1'b1)
    cfg(8'h00, 4'h1, 4'h0);
    `CHK(hi inside {[MON:MON+3]}, 1'b1)
    cfg(8'h00, 4'h1, 4'h2);
    `CHK(hi inside {[LEB:LEB+4]}, 1'b1)
    cfg(8'h28, 4'h0, 4'h0);
    `CHK(lo inside {[MOFF:MOFF+4]}, 1'b1)
    fb = 3'h0;
    nring = 4'h7;
    wait_n(1800);
    `CHK(valley, 3'h7)
    fb = 3'h1;
    wait_n(400);
    `CHK(valley, 3'h7)
    fb = 3'h3;
    for (hi = 0; valley === 3'h7 && hi < 300; hi++) wait_n(1);
    `CHK(valley, 3'h6)
    fb = 3'h7;
    wait_n(5);
    `CHK(valley, 3'h1)
    fb = 3'h3;
    wait_n(400);
    `CHK(valley, 3'h1)
    nring = 4'h0;
    flt = 4'h4;
    wait_n(600);
    `CHK({latched, gate}, 2'h2)
    flt = 4'h0;
    wait_n(50);
    `CHK(latched, 1'b1)
    i_power_down = 1'b1;
    wait_n(10);
    i_power_down = 1'b0;
    `CHK(latched, 1'b0)
    onl = 8'h00;
    flt = 4'h1;
    wait_n(600);
    `CHK({latched, gate}, 2'h2)
    give_verdict();
  end
endmodule
`default_nettype wire
